// ===== design/swc_pkg.sv
// Purpose: shared constants for suspend and warm-up control
// Assumes: 25 MHz oscillator clock, APB register access
// Notes: offsets are byte addresses on a 32-bit APB
package swc_pkg;
  localparam logic [11:0] ADDR_POWER_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_SUSPEND_KEY = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [7:0] SUSPEND_KEY_VALUE = 8'h55;
  localparam logic [3:0] POWER_CONTROL_RST = 4'h0;
  localparam logic [7:0] SUSPEND_KEY_RST = 8'h00;
  localparam int HALT_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int FLAG_A_BIT = 2;
  localparam int FLAG_B_BIT = 3;
  localparam int OPT_RESET_PIN_BIT = 5;
  localparam int OPT_BROWNOUT_BIT = 4;
  localparam int OPT_WATCHDOG_BIT = 3;
  localparam logic [2:0] OSC_CERAMIC_A = 3'h5;
  localparam logic [2:0] OSC_CERAMIC_B = 3'h6;
  localparam int WARM_RC_CLKS = 128;
  localparam int WARM_CERAMIC_CLKS = 4096;
  localparam int CLK_HZ = 25_000_000;
  localparam int REGULATOR_SETTLE_MS = 6;
  localparam int SETTLE_CYCLES_DEF = (REGULATOR_SETTLE_MS * CLK_HZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_WARM,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_HOLD
  } swc_state_t;

  function automatic logic swc_is_ceramic(input logic [2:0] osc);
    return (osc == OSC_CERAMIC_A) || (osc == OSC_CERAMIC_B);
  endfunction : swc_is_ceramic
endpackage : swc_pkg

// ===== design/swc_top.sv
// Purpose: halt and clock-stop entry and exit, warm-up gating
// Assumes: option straps stable at reset release
// Notes: registers reached over APB with no wait states
// Functional notes
// RL1: stop bit after key enters clock stop; interrupt or reset clears it.
// RL2: halt bit after key enters CPU halt; interrupt or reset clears it.
// RL3: both bits set means clock stop; halt request ignored.
// RL4: software writes key 55H then mode bit in the very next access.
// RL5: broken sequence clears key or mode bit a cycle later, no entry.
// RL6: halt stops CPU clock only; peripherals keep running.
// RL7: clock stop gates every clock and the oscillator.
// RL8: warm-up runs after power-on, pin, brownout reset and stop wake.
// RL9: RC oscillator warm-up lasts 128 clocks.
// RL10: ceramic resonator warm-up lasts 4096 clocks.
// RL11: power-on waits about 6 ms for regulator before warm-up.
// RL12: option bit 5 picks reset pin (0) or general I/O (1).
// RL13: option bit 4 enables brownout reset.
// RL14: option bit 3 enables watchdog.
// RL15: oscillator codes 101 and 110 pick ceramic, others RC.
// RL16: power control bits 3 and 2 are plain software flags.
// RL17: leaving low power also clears the suspend key.
// RL18: software places three no-ops after the mode bit write.
// RL19: interrupt in clock stop restarts oscillator, warms up, then resumes.
// RL20: reset out of low power restarts at zero, memory untouched.
// RL21: warm-up counts raw clocks with clock gates held closed.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module swc_top
  import swc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF,
  parameter int SW = 18
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [5:0] option_i,
  input wire logic reset_pin_b_i,
  input wire logic brownout_i,
  input wire logic wdt_reset_i,
  input wire logic irq_i,
  input wire logic ext_irq_i,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic cpu_reset_o,
  output logic halt_o,
  output logic stop_o,
  output logic pin_is_gpio_o,
  output logic brownout_en_o,
  output logic watchdog_en_o,
  output logic ceramic_sel_o
);
  swc_state_t state_reg;
  swc_state_t state_next;
  logic [5:0] opt_reg;
  logic opt_loaded_reg;
  logic [3:0] power_control_reg;
  logic [7:0] suspend_key_reg;
  logic armed_reg;
  logic kill_key_reg;
  logic kill_mode_reg;
  logic need_warm_reg;
  logic from_reset_reg;
  logic [SW-1:0] settle_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic pin_rst;
  logic bo_rst;
  logic wd_rst;
  logic any_rst;
  logic acc;
  logic wr;
  logic key_wr;
  logic power_control_wr;
  logic mode_req;
  logic enter;
  logic exit_lp;
  logic settle_done;
  logic mapped;

  swc_wu_if wu ();

  swc_warmup #(
    .CW(13)
  ) u_warmup (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wu(wu.cnt)
  );

  // option straps caught once after reset release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_reg <= 6'h00;
      opt_loaded_reg <= 1'b0;
    end else if (!opt_loaded_reg) begin
      opt_reg <= option_i;
      opt_loaded_reg <= 1'b1;
    end
  end

  assign pin_is_gpio_o = opt_reg[OPT_RESET_PIN_BIT]; // [RL12]
  assign brownout_en_o = opt_reg[OPT_BROWNOUT_BIT]; // [RL13]
  assign watchdog_en_o = opt_reg[OPT_WATCHDOG_BIT]; // [RL14]
  assign ceramic_sel_o = swc_is_ceramic(opt_reg[2:0]); // [RL15]
  assign wu.ceramic = ceramic_sel_o;

  // reset sources, each gated by its option
  assign pin_rst = !opt_reg[OPT_RESET_PIN_BIT] && !reset_pin_b_i; // [RL12]
  assign bo_rst = opt_reg[OPT_BROWNOUT_BIT] && brownout_i; // [RL13]
  assign wd_rst = opt_reg[OPT_WATCHDOG_BIT] && wdt_reset_i; // [RL14]
  assign any_rst = opt_loaded_reg && (pin_rst || bo_rst || wd_rst);

  // bus decode
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign key_wr = wr && (paddr_i == ADDR_SUSPEND_KEY);
  assign power_control_wr = wr && (paddr_i == ADDR_POWER_CONTROL);
  assign mode_req = power_control_wr && (pwdata_i[HALT_BIT] || pwdata_i[STOP_BIT]);
  assign enter = mode_req && armed_reg && (state_reg == ST_RUN)
    && (suspend_key_reg == SUSPEND_KEY_VALUE); // [RL1] [RL2]
  assign mapped = (paddr_i == ADDR_POWER_CONTROL) || (paddr_i == ADDR_SUSPEND_KEY)
    || (paddr_i == ADDR_STATUS);
  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;
  assign pslverr_o = slverr_reg && acc;

  // key armed only until the next completed access
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_reg <= 1'b0;
    end else if (any_rst) begin
      armed_reg <= 1'b0;
    end else if (acc) begin
      armed_reg <= key_wr && (pwdata_i[7:0] == SUSPEND_KEY_VALUE);
    end
  end

  // broken sequence cleanup, one cycle later
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kill_key_reg <= 1'b0;
      kill_mode_reg <= 1'b0;
    end else begin
      kill_key_reg <= acc && armed_reg && !enter; // [RL5]
      kill_mode_reg <= mode_req && !enter; // [RL5]
    end
  end

  assign exit_lp = ((state_reg == ST_HALT) && irq_i)
    || ((state_reg == ST_STOP) && ext_irq_i)
    || (((state_reg == ST_HALT) || (state_reg == ST_STOP)) && any_rst);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_control_reg <= POWER_CONTROL_RST;
    end else if (any_rst) begin
      power_control_reg <= POWER_CONTROL_RST; // [RL1] [RL2]
    end else if (exit_lp) begin
      power_control_reg[STOP_BIT] <= 1'b0; // [RL1]
      power_control_reg[HALT_BIT] <= 1'b0; // [RL2]
    end else if (power_control_wr) begin
      power_control_reg <= pwdata_i[3:0]; // [RL16]
    end else if (kill_mode_reg) begin
      power_control_reg[STOP_BIT] <= 1'b0; // [RL5]
      power_control_reg[HALT_BIT] <= 1'b0; // [RL5]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      suspend_key_reg <= SUSPEND_KEY_RST;
    end else if (any_rst || exit_lp) begin
      suspend_key_reg <= SUSPEND_KEY_RST; // [RL17]
    end else if (key_wr) begin
      suspend_key_reg <= pwdata_i[7:0];
    end else if (kill_key_reg) begin
      suspend_key_reg <= SUSPEND_KEY_RST; // [RL5]
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (psel_i && !penable_i) begin
      slverr_reg <= !mapped;
      unique case (paddr_i)
        ADDR_POWER_CONTROL: prdata_reg <= {28'h0000000, power_control_reg};
        ADDR_SUSPEND_KEY: prdata_reg <= {24'h000000, suspend_key_reg};
        ADDR_STATUS: prdata_reg <= {18'h00000, opt_reg, 3'h0, wu.busy,
          from_reset_reg, stop_o, halt_o, cpu_clk_en_o};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // regulator settle after power-on
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_reg <= '0;
    end else if (state_reg == ST_SETTLE) begin
      settle_reg <= settle_reg + 1'b1; // [RL11]
    end
  end

  assign settle_done = (settle_reg == SW'(SETTLE_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      need_warm_reg <= 1'b0;
    end else if (any_rst) begin
      // stop or cut warm-up: oscillator not yet trusted
      need_warm_reg <= ((state_reg == ST_HOLD) && need_warm_reg) || (state_reg == ST_STOP)
        || (state_reg == ST_WARM) || pin_rst || bo_rst; // [RL8]
    end
  end

  // restart from zero after reset; memory is not touched here
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      from_reset_reg <= 1'b1;
    end else if (any_rst && (state_reg != ST_SETTLE)) begin
      from_reset_reg <= 1'b1; // [RL20]
    end else if (state_next == ST_RUN) begin
      from_reset_reg <= 1'b0;
    end
  end

  assign wu.start = ((state_reg == ST_SETTLE) && settle_done)
    || ((state_reg == ST_HOLD) && !any_rst && need_warm_reg)
    || ((state_reg == ST_STOP) && ext_irq_i && !any_rst); // [RL8] [RL19]

  always_comb begin
    state_next = state_reg;
    if (any_rst && (state_reg != ST_SETTLE)) begin
      state_next = ST_HOLD;
    end else begin
      unique case (state_reg)
        ST_SETTLE: if (settle_done) state_next = ST_WARM; // [RL11]
        ST_HOLD: state_next = need_warm_reg ? ST_WARM : ST_RUN; // [RL8]
        ST_WARM: if (wu.done) state_next = ST_RUN; // [RL21]
        ST_RUN: begin
          if (enter) begin
            state_next = pwdata_i[STOP_BIT] ? ST_STOP : ST_HALT; // [RL3]
          end
        end
        ST_HALT: if (irq_i) state_next = ST_RUN; // [RL2]
        ST_STOP: if (ext_irq_i) state_next = ST_WARM; // [RL19]
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_SETTLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cpu_clk_en_o = (state_reg == ST_RUN); // [RL6] [RL21]
  assign periph_clk_en_o = (state_reg == ST_RUN) || (state_reg == ST_HALT); // [RL6] [RL7]
  assign osc_en_o = (state_reg != ST_STOP); // [RL7]
  assign halt_o = (state_reg == ST_HALT);
  assign stop_o = (state_reg == ST_STOP);
  assign cpu_reset_o = from_reset_reg && (state_reg != ST_RUN); // [RL20]

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_stop_clocks;
    stop_o |-> !cpu_clk_en_o && !periph_clk_en_o && !osc_en_o;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock stop leaks a clock"); // [RL7]

  property p_halt_clocks;
    halt_o |-> periph_clk_en_o && !cpu_clk_en_o;
  endproperty
  a_halt_clocks: assert property (p_halt_clocks) else $error("halt clock gating wrong"); // [RL6]

  property p_stop_wins;
    (enter && pwdata_i[STOP_BIT] && pwdata_i[HALT_BIT] && !any_rst) |=> stop_o && !halt_o;
  endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("halt taken over stop"); // [RL3]

  property p_halt_entry;
    (enter && !pwdata_i[STOP_BIT] && !any_rst) |=> halt_o;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt not entered"); // [RL2]

  property p_key_reject;
    (acc && armed_reg && !enter && !any_rst) |-> ##2 (suspend_key_reg == SUSPEND_KEY_RST);
  endproperty
  a_key_reject: assert property (p_key_reject) else $error("key not cleared"); // [RL5]

  property p_exit_clears;
    (exit_lp) |=> (power_control_reg[1:0] == 2'h0) && (suspend_key_reg == SUSPEND_KEY_RST);
  endproperty
  a_exit_clears: assert property (p_exit_clears) else $error("exit left bits set"); // [RL1] [RL17]

  property p_stop_wake;
    (stop_o && ext_irq_i && !any_rst) |=> wu.busy && !cpu_clk_en_o ##1 osc_en_o;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake skipped warm-up"); // [RL19]

  property p_warm_gated;
    wu.busy |-> !cpu_clk_en_o && !periph_clk_en_o;
  endproperty
  a_warm_gated: assert property (p_warm_gated) else $error("clock open during warm-up"); // [RL21]

  property p_flags_kept;
    (halt_o && irq_i && !any_rst) |=> (power_control_reg[3:2] == $past(power_control_reg[3:2]));
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("user flags disturbed"); // [RL16]

  property p_settle_then_warm;
    ((state_reg == ST_SETTLE) && settle_done && !any_rst) |=> (state_reg == ST_WARM) && wu.busy;
  endproperty
  a_settle_then_warm: assert property (p_settle_then_warm) else $error("settle did not start warm-up"); // [RL11]

  property p_halt_exit;
    (halt_o && irq_i && !any_rst) |=> cpu_clk_en_o && !halt_o;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt not left on interrupt"); // [RL2]

  property p_reset_restart;
    (any_rst && (state_reg != ST_SETTLE)) |=> cpu_reset_o && !cpu_clk_en_o && !halt_o && !stop_o;
  endproperty
  a_reset_restart: assert property (p_reset_restart) else $error("reset did not restart"); // [RL20]

  property p_mode_kill;
    (mode_req && !enter && !any_rst) |-> ##2 (power_control_reg[1:0] == 2'h0);
  endproperty
  a_mode_kill: assert property (p_mode_kill) else $error("stray mode bit kept"); // [RL5]

  property p_warm_release;
    ((state_reg == ST_WARM) && wu.done && !any_rst) |=> cpu_clk_en_o && periph_clk_en_o && !wu.busy;
  endproperty
  a_warm_release: assert property (p_warm_release) else $error("clocks not released after warm-up"); // [RL21]
endmodule : swc_top
`default_nettype wire

// ===== design/swc_warmup.sv
// Purpose: oscillator warm-up counter
// Assumes: ceramic select stable during a count
// Notes: busy lasts exactly the selected number of clocks
`timescale 1ns/10ps
`default_nettype none
module swc_warmup
  import swc_pkg::*;
#(
  parameter int CW = 13
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  swc_wu_if.cnt wu
);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  logic [CW-1:0] term;
  logic [CW:0] run_len_reg;

  assign term = wu.ceramic ? CW'(WARM_CERAMIC_CLKS - 1) : CW'(WARM_RC_CLKS - 1); // [RL9] [RL10]
  assign wu.busy = busy_reg;
  assign wu.done = busy_reg && (cnt_reg == term);

  // raw oscillator cycles, no prescale
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (wu.start) begin
      busy_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (busy_reg) begin
      if (cnt_reg == term) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1; // [RL21]
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_len_reg <= '0;
    end else if (wu.start) begin
      run_len_reg <= '0;
    end else if (busy_reg) begin
      run_len_reg <= run_len_reg + 1'b1;
    end
  end

  property p_warm_len;
    @(posedge clk_i) disable iff (!rst_b_i)
    $fell(busy_reg) |-> (run_len_reg == (wu.ceramic ? (CW+1)'(WARM_CERAMIC_CLKS) : (CW+1)'(WARM_RC_CLKS)));
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong"); // [RL9] [RL10]
endmodule : swc_warmup
`default_nettype wire

// ===== design/swc_wu_if.sv
// Purpose: link between controller and warm-up counter
// Assumes: one clock domain
// Notes: start restarts a running count
`timescale 1ns/10ps
`default_nettype none
interface swc_wu_if;
  logic start;
  logic ceramic;
  logic busy;
  logic done;
  modport ctrl (output start, output ceramic, input busy, input done);
  modport cnt (input start, input ceramic, output busy, output done);
endinterface : swc_wu_if
`default_nettype wire

// ===== verif/swc_top_tb_top.sv
// Purpose: self-checking bench for suspend and warm-up control
// Assumes: zero-wait APB slave, shortened regulator settle
// Notes: transfer results checked from a queue of expected words
`timescale 1ns/10ps
`default_nettype none
module swc_top_tb_top;
  import swc_pkg::*;
  localparam int SETTLE = 10;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [5:0] option_i = 6'h08;
  logic reset_pin_b_i = 1'b1;
  logic brownout_i = 1'b0;
  logic wdt_reset_i = 1'b0;
  logic irq_i = 1'b0;
  logic ext_irq_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o, cpu_reset_o;
  logic halt_o, stop_o, pin_is_gpio_o, brownout_en_o, watchdog_en_o, ceramic_sel_o;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [31:0] seed = 32'h6679;
  logic [32:0] exq[$];
  logic [32:0] exp_w;

  always #20 clk_i = ~clk_i;

  swc_top #(.SETTLE_CYCLES(SETTLE)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .option_i(option_i),
    .reset_pin_b_i(reset_pin_b_i), .brownout_i(brownout_i), .wdt_reset_i(wdt_reset_i),
    .irq_i(irq_i), .ext_irq_i(ext_irq_i), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .osc_en_o(osc_en_o), .cpu_reset_o(cpu_reset_o),
    .halt_o(halt_o), .stop_o(stop_o), .pin_is_gpio_o(pin_is_gpio_o),
    .brownout_en_o(brownout_en_o), .watchdog_en_o(watchdog_en_o), .ceramic_sel_o(ceramic_sel_o));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t transfer got %h want %h", $time, got, exp);
    end
  endtask : cmp_word

  // result watcher: one queued note per completed transfer
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
    if (psel_i && penable_i && pready_o === 1'b1) begin
      exp_w = exq.pop_front();
      cmp_word(pwrite_i ? {pslverr_o, exp_w[31:0]} : {pslverr_o, prdata_o}, exp_w);
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    exq.push_back(e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    chk(k < 50, 1'b1, "no ready");
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {1'b0, 32'h0});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task automatic wait_run(output int k);
    k = 0;
    while (cpu_clk_en_o !== 1'b1 && k < 8000) begin
      @(posedge clk_i);
      k++;
    end
    #1;
  endtask : wait_run

  task automatic rst_run(input logic [5:0] opt, output int k);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    option_i <= opt;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    wait_run(k);
  endtask : rst_run

  // 0 pin, 1 brownout, 2 watchdog; exp says whether it must act
  task automatic rst_try(input int which, input logic exp);
    int k;
    wr(ADDR_POWER_CONTROL, 32'h0000000C);
    @(posedge clk_i);
    case (which)
      0: reset_pin_b_i <= 1'b0;
      1: brownout_i <= 1'b1;
      default: wdt_reset_i <= 1'b1;
    endcase
    repeat (2) @(posedge clk_i);
    #1;
    chk(cpu_reset_o, exp, "internal reset response");
    @(posedge clk_i);
    reset_pin_b_i <= 1'b1;
    brownout_i <= 1'b0;
    wdt_reset_i <= 1'b0;
    wait_run(k);
    chk(cpu_clk_en_o, 1'b1, "run after reset");
    rd(ADDR_POWER_CONTROL, exp ? 32'h0 : 32'h0000000C);
  endtask : rst_try

  initial begin
    rst_run(6'h08, n);
    chk(n >= SETTLE + WARM_RC_CLKS && n <= SETTLE + WARM_RC_CLKS + 4, 1'b1, "rc warm-up");
    chk(cpu_reset_o, 1'b0, "cpu reset after warm-up");
    rd(ADDR_POWER_CONTROL, 32'h0);
    rd(ADDR_SUSPEND_KEY, 32'h0);
    rd(ADDR_STATUS, 32'h0000_0801);
    $display("test reset done");
    wr(ADDR_SUSPEND_KEY, 32'h55);
    wr(ADDR_POWER_CONTROL, 32'h1);
    repeat (3) @(posedge clk_i);
    #1;
    chk(halt_o, 1'b1, "halt entry");
    chk(cpu_clk_en_o, 1'b0, "cpu clock in halt");
    chk(periph_clk_en_o, 1'b1, "peripheral clock in halt");
    @(posedge clk_i);
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    #1;
    chk(halt_o | ~cpu_clk_en_o, 1'b0, "halt exit");
    rd(ADDR_POWER_CONTROL, 32'h0);
    rd(ADDR_SUSPEND_KEY, 32'h0);
    $display("test halt done");
    wr(ADDR_SUSPEND_KEY, 32'h55);
    wr(ADDR_POWER_CONTROL, 32'h3);
    repeat (3) @(posedge clk_i);
    #1;
    chk(stop_o & ~halt_o, 1'b1, "both bits give stop");
    chk(osc_en_o | periph_clk_en_o | cpu_clk_en_o, 1'b0, "clocks in stop");
    @(posedge clk_i);
    ext_irq_i <= 1'b1;
    @(posedge clk_i);
    ext_irq_i <= 1'b0;
    #1;
    chk(osc_en_o & ~periph_clk_en_o & ~stop_o, 1'b1, "oscillator restart, clocks held");
    wait_run(n);
    chk(n >= WARM_RC_CLKS - 4 && n <= WARM_RC_CLKS + 2, 1'b1, "stop wake warm-up");
    rd(ADDR_POWER_CONTROL, 32'h0);
    rd(ADDR_SUSPEND_KEY, 32'h0);
    $display("test stop done");
    wr(ADDR_SUSPEND_KEY, 32'h55);
    rd(ADDR_SUSPEND_KEY, 32'h55);
    rd(ADDR_SUSPEND_KEY, 32'h0);
    wr(ADDR_POWER_CONTROL, 32'h1);
    repeat (2) @(posedge clk_i);
    #1;
    chk(halt_o, 1'b0, "no halt without key");
    rd(ADDR_POWER_CONTROL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_POWER_CONTROL, seed & 32'hFFFFFFFC);
      rd(ADDR_POWER_CONTROL, {28'h0, seed[3:2], 2'b00});
      chk(halt_o | stop_o, 1'b0, "flags have no effect");
    end
    apb(1'b1, 12'h00C, seed, {1'b1, 32'h0});
    apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
    $display("test sequence and flags done");
    rst_try(0, 1'b1);
    rst_try(1, 1'b0);
    rst_try(2, 1'b1);
    $display("test internal resets done");
    for (int c = 0; c < 8; c++) begin
      rst_run({c[2:0], c[2:0]}, n);
      chk(pin_is_gpio_o, c[2], "reset pin option");
      chk(brownout_en_o, c[1], "brownout option");
      chk(watchdog_en_o, c[0], "watchdog option");
      chk(ceramic_sel_o, c == 5 || c == 6, "oscillator option");
      chk(n >= SETTLE + ((c == 5 || c == 6) ? WARM_CERAMIC_CLKS : WARM_RC_CLKS), 1'b1, "warm-up low");
      chk(n <= SETTLE + ((c == 5 || c == 6) ? WARM_CERAMIC_CLKS : WARM_RC_CLKS) + 4, 1'b1, "warm-up high");
    end
    rst_try(0, 1'b0);
    rst_try(1, 1'b1);
    $display("test options done");
    conclude();
  end
endmodule : swc_top_tb_top
`default_nettype wire
